//--- ffoc_defs.vh
// Constants for the flag offset configuration and fall-through flag block.
`ifndef FFOC_DEFS_VH
`define FFOC_DEFS_VH
`define FFOC_DW        18
`define FFOC_OW        11
`define FFOC_DEPTH     5'h08
`define FFOC_AW        3
`define FFOC_CW        4
`define FFOC_OFF_1023  11'h3ff
`define FFOC_OFF_511   11'h1ff
`define FFOC_OFF_255   11'h0ff
`define FFOC_OFF_127   11'h07f
`define FFOC_OFF_63    11'h03f
`define FFOC_OFF_31    11'h01f
`define FFOC_OFF_15    11'h00f
`define FFOC_OFF_7     11'h007
`define FFOC_OFF_3     11'h003
`endif

//--- ffoc_top.v
// Offset configuration, fall-through buffer and its status flags.
`timescale 1ns/1ps
`include "ffoc_defs.vh"

module ffoc_fifo #(
  parameter DW = 18,
  parameter AW = 3,
  parameter CW = 4
) (
  input  wire          core_clk_i, // Clock.
  input  wire          rst_n_i,    // Synchronous reset, active low.
  input  wire          in_valid_i, // Write request.
  output wire          in_ready_o, // Room available.
  input  wire [DW-1:0] in_data_i,  // Write data.
  output wire          out_valid_o,// Word available.
  input  wire          out_ready_i,// Read request.
  output wire [DW-1:0] out_data_o, // Head word.
  output wire [CW-1:0] count_o     // Stored words.
);
  localparam integer DEPTH = 1 << AW;
  reg [DW-1:0] mem [0:(1<<AW)-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [CW-1:0] cnt_r;
  wire         wr;
  wire         rd;
  assign in_ready_o  = (cnt_r != DEPTH[CW-1:0]);
  assign out_valid_o = (cnt_r != {CW{1'b0}});
  assign wr          = in_valid_i & in_ready_o;
  assign rd          = out_ready_i & out_valid_o;
  assign out_data_o  = mem[rp_r];
  assign count_o     = cnt_r;
  always @(posedge core_clk_i) begin
    if (wr) begin
      mem[wp_r] <= in_data_i;
    end
    if (!rst_n_i) begin
      wp_r  <= {AW{1'b0}};
      rp_r  <= {AW{1'b0}};
      cnt_r <= {CW{1'b0}};
    end else begin
      if (wr) begin
        wp_r <= wp_r + 1'b1;
      end
      if (rd) begin
        rp_r <= rp_r + 1'b1;
      end
      if (wr && !rd) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (rd && !wr) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule // ffoc_fifo

// Delay chain for one status flag; clear loads the flag's idle level.
module ffoc_dly #(
  parameter       N    = 2,
  parameter [0:0] INIT = 1'b0
) (
  input  wire core_clk_i, // Clock.
  input  wire clr_i,      // Load idle level, active high.
  input  wire d_i,        // Flag in.
  output wire q_o         // Flag after N stages.
);
  reg [N-1:0] sr_r;
  always @(posedge core_clk_i) begin
    if (clr_i) begin
      sr_r <= {N{INIT}};
    end else begin
      sr_r <= {sr_r[N-2:0], d_i};
    end
  end
  assign q_o = sr_r[N-1];
endmodule // ffoc_dly

module ffoc_top (
  input  wire                 core_clk_i,        // Clock, 50 MHz.
  input  wire                 rst_n_i,           // Sync reset, active low.
  input  wire                 master_reset_n_i,  // Master reset, low.
  input  wire                 load_method_select_i, // Load method pin.
  input  wire                 offset_select_hi_i,   // Offset select high.
  input  wire                 offset_select_lo_i,   // Offset select low.
  input  wire                 small_capacity_i,  // Smallest capacity part.
  input  wire                 narrow_mode_i,     // Narrow in, narrow out.
  input  wire                 wr_en_i,           // Write request.
  input  wire [`FFOC_DW-1:0]  wr_data_i,         // Write data.
  input  wire                 rd_en_i,           // Read request.
  input  wire                 prog_en_i,         // Parallel offset write.
  input  wire                 prog_sel_full_i,   // 1 full, 0 empty offset.
  input  wire [`FFOC_OW-1:0]  prog_value_i,      // Offset value.
  input  wire                 offset_read_i,     // Show offsets on bus.
  output reg  [`FFOC_DW-1:0]  parallel_output_bus_o, // Data or offset.
  output reg                  input_ready_flag_o,    // High when full.
  output reg                  output_ready_flag_o,   // High when empty.
  output reg                  almost_empty_flag_o,   // Low when near empty.
  output reg                  almost_full_flag_o,    // Low when near full.
  output reg                  serial_mode_o          // Serial programming.
);
  reg  [`FFOC_OW-1:0] empty_off_r;
  reg  [`FFOC_OW-1:0] full_off_r;
  reg  [`FFOC_OW-1:0] dflt;
  wire                flag_clr;
  wire                inrdy_dly;
  wire                outrdy_dly;
  wire                fifo_in_ready;
  wire                fifo_out_valid;
  wire [`FFOC_DW-1:0] fifo_data;
  wire [`FFOC_CW-1:0] count;
  wire                load_ok;
  wire                wr_go;
  wire                rd_go;
  wire [`FFOC_CW:0]   cnt_w;
  wire [`FFOC_CW:0]   cap_w;
  wire                prog_ok;

  // Host keeps load select high to move data; low gates the data ports.
  assign load_ok = load_method_select_i;
  assign wr_go   = wr_en_i & load_ok & master_reset_n_i;
  assign rd_go   = rd_en_i & load_ok & master_reset_n_i & ~offset_read_i;
  assign cnt_w   = {1'b0, count};
  // Either reset returns the flag chains to their idle levels.
  assign flag_clr = ~rst_n_i | ~master_reset_n_i;
  assign cap_w   = `FFOC_DEPTH;
  // Programmed values of the depth or more are dropped; the offsets loaded
  // at either reset are not checked against the depth.
  assign prog_ok = prog_en_i & ~serial_mode_o & master_reset_n_i &
                   ({{(`FFOC_CW+1){1'b0}}, prog_value_i} < cap_w);

  // Depth words live in the memory; the head word is read from it directly.
  ffoc_fifo #(
    .DW (`FFOC_DW),
    .AW (`FFOC_AW),
    .CW (`FFOC_CW)
  ) u_fifo (
    .core_clk_i  (core_clk_i),
    .rst_n_i     (rst_n_i & master_reset_n_i),
    .in_valid_i  (wr_go),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (wr_data_i),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (rd_go),
    .out_data_o  (fifo_data),
    .count_o     (count)
  );

  // Each chain is followed by the output flop, so a pin lags the buffer
  // state by one cycle more than its chain; the host must allow for the
  // extra cycle before trusting a flag after a write or read.
  ffoc_dly #(
    .N    (2),
    .INIT (1'b0)
  ) u_inrdy_dly (
    .core_clk_i (core_clk_i),
    .clr_i      (flag_clr),
    .d_i        (~fifo_in_ready),
    .q_o        (inrdy_dly)
  );

  ffoc_dly #(
    .N    (3),
    .INIT (1'b1)
  ) u_outrdy_dly (
    .core_clk_i (core_clk_i),
    .clr_i      (flag_clr),
    .d_i        (~fifo_out_valid),
    .q_o        (outrdy_dly)
  );

  always @* begin
    case ({load_method_select_i, offset_select_hi_i, offset_select_lo_i})
      3'b010:  dflt = `FFOC_OFF_511;
      3'b001:  dflt = `FFOC_OFF_255;
      3'b000:  dflt = `FFOC_OFF_127;
      3'b011:  dflt = `FFOC_OFF_63;
      3'b100:  dflt = !small_capacity_i ? `FFOC_OFF_1023 :
                      (narrow_mode_i ? `FFOC_OFF_1023 : `FFOC_OFF_31);
      3'b110:  dflt = (small_capacity_i && !narrow_mode_i) ?
                      `FFOC_OFF_15 : `FFOC_OFF_31;
      3'b101:  dflt = (small_capacity_i && !narrow_mode_i) ?
                      `FFOC_OFF_7 : `FFOC_OFF_15;
      3'b111:  dflt = (small_capacity_i && !narrow_mode_i) ?
                      `FFOC_OFF_3 : `FFOC_OFF_7;
      default: dflt = `FFOC_OFF_127;
    endcase
  end

  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      empty_off_r <= `FFOC_OFF_127;
      full_off_r  <= `FFOC_OFF_127;
      serial_mode_o <= 1'b0;
    end else if (!master_reset_n_i) begin
      empty_off_r   <= dflt;
      full_off_r    <= dflt;
      serial_mode_o <= load_method_select_i;
    end else if (prog_ok) begin
      if (prog_sel_full_i) begin
        full_off_r <= prog_value_i;
      end else begin
        empty_off_r <= prog_value_i;
      end
    end
  end

  always @(posedge core_clk_i) begin
    if (flag_clr) begin
      input_ready_flag_o    <= 1'b0;
      output_ready_flag_o   <= 1'b1;
      almost_empty_flag_o   <= 1'b0;
      almost_full_flag_o    <= 1'b1;
      parallel_output_bus_o <= {`FFOC_DW{1'b0}};
    end else begin
      // Full raises input-ready, the first read from full drops it.
      input_ready_flag_o <= inrdy_dly;
      // Empty raises output-ready, the first write drops it.
      output_ready_flag_o <= outrdy_dly;
      almost_empty_flag_o <=
        (cnt_w > ({2'b00, empty_off_r[`FFOC_CW-1:0]} + 5'h01));
      almost_full_flag_o <=
        (cnt_w < (cap_w - {2'b00, full_off_r[`FFOC_CW-1:0]}));
      if (offset_read_i) begin
        parallel_output_bus_o <= prog_sel_full_i ?
          {7'h00, full_off_r} : {7'h00, empty_off_r};
      end else begin
        parallel_output_bus_o <= fifo_data;
      end
    end
  end
endmodule // ffoc_top

//--- ffoc_host.sv
// Host model that streams bursts into or out of the buffer.
`timescale 1ns/1ps
module ffoc_host (
  input  wire        clk_i,   // Clock.
  input  wire        go_i,    // Start burst.
  input  wire        rd_i,    // 1 read, 0 write.
  input  wire [3:0]  n_i,     // Burst words.
  output reg         wr_en_o, // Write.
  output reg         rd_en_o, // Read.
  output reg  [17:0] data_o   // Data.
);
  reg [3:0] left_r = 4'h0;
  initial begin
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    data_o = 18'h00000;
  end
  always @(negedge clk_i) begin
    if (go_i)
      left_r <= n_i;
    else if (left_r != 4'h0)
      left_r <= left_r - 4'h1;
    wr_en_o <= !go_i && !rd_i && left_r != 4'h0;
    rd_en_o <= !go_i && rd_i && left_r != 4'h0;
    // Idle data flips so a stale word never looks fresh.
    data_o <= (left_r != 4'h0) ? 18'h2a500 + left_r : ~data_o;
  end
endmodule // ffoc_host

//--- ffoc_chk.sv
// Port assertions for the flag offset block.
`timescale 1ns/1ps
`include "ffoc_defs.vh"
module ffoc_chk (
  input wire                core_clk_i,            // Clock.
  input wire                rst_n_i,               // Reset.
  input wire                master_reset_n_i,      // Master.
  input wire                load_method_select_i,  // Load.
  input wire                wr_en_i,               // Write.
  input wire                rd_en_i,               // Read.
  input wire                prog_en_i,             // Program.
  input wire                offset_read_i,         // Readback.
  input wire [`FFOC_DW-1:0] parallel_output_bus_o, // Bus.
  input wire                input_ready_flag_o,    // Full.
  input wire                output_ready_flag_o,   // Empty.
  input wire                almost_empty_flag_o,   // Near empty.
  input wire                serial_mode_o          // Serial.
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  reg [4:0] wr_h_r;
  reg [4:0] rd_h_r;
  always @(posedge core_clk_i) begin
    wr_h_r <= {wr_h_r[3:0], wr_en_i};
    rd_h_r <= {rd_h_r[3:0], rd_en_i || prog_en_i};
  end
  a_mode_latch:
    assert property (!master_reset_n_i |=> serial_mode_o ==
      $past(load_method_select_i)) else $error("mode not latched");
  a_mode_hold:
    assert property (master_reset_n_i && $past(master_reset_n_i) &&
      $past(rst_n_i) |-> $stable(serial_mode_o)) else $error("mode moved");
  a_reset_flags:
    assert property (!master_reset_n_i |=> output_ready_flag_o &&
      !input_ready_flag_o && !almost_empty_flag_o) else $error("reset flags");
  a_or_fall:
    assert property ($fell(output_ready_flag_o) |-> |wr_h_r[4:2])
      else $error("ready fell without write");
  a_or_rise:
    assert property ($rose(output_ready_flag_o) |-> |rd_h_r[4:2] ||
      !$past(master_reset_n_i)) else $error("empty without read");
  a_inrdy_rise:
    assert property ($rose(input_ready_flag_o) |-> |wr_h_r[3:1])
      else $error("full without write");
  a_inrdy_fall:
    assert property ($fell(input_ready_flag_o) |-> |rd_h_r[3:1] ||
      !$past(master_reset_n_i)) else $error("room without read");
  a_ae_fall:
    assert property ($fell(almost_empty_flag_o) |-> |rd_h_r[2:0] ||
      !$past(master_reset_n_i)) else $error("near empty unprompted");
  a_offset_show:
    assert property ($past(offset_read_i) |->
      parallel_output_bus_o[17:11] == 7'h00) else $error("offset high bits");
  a_outrdy_lag:
    assert property ($fell(output_ready_flag_o) |-> wr_h_r[4])
      else $error("output ready lag wrong");
  a_inrdy_lag:
    assert property ($rose(input_ready_flag_o) |-> wr_h_r[3])
      else $error("input ready lag wrong");
endmodule // ffoc_chk
bind ffoc_top ffoc_chk u_chk (.*);

//--- testbench.sv
// Self-checking bench for the flag offset block.
`timescale 1ns/1ps
module testbench;
  reg core_clk_i = 1'b0, rst_n_i = 1'b0, mr_n = 1'b1, lsel = 1'b1, hi = 1'b0;
  reg lo = 1'b0, sm = 1'b0, nw = 1'b0, pen = 1'b0, psel = 1'b0;
  reg offrd = 1'b0, go = 1'b0, rdsel = 1'b0;
  reg [3:0] n = 4'h0;
  reg [10:0] pval = 11'h000;
  reg [15:0] r;
  wire wr_en, rd_en, in_rdy, orf, ae, af, ser;
  wire [17:0] wdata, bus;
  integer n_errors = 0, comparisons = 0, cyc = 0, i;
  // Straps ld,hi,lo,small,narrow then the expected offset.
  localparam [271:0] rows = {16'h83ff, 16'h41ff, 16'h20ff, 16'h007f,
    16'h603f, 16'hc01f, 16'ha00f, 16'he007,
    16'h901f, 16'hd00f, 16'hb007, 16'hf003, 16'h9bff, 16'hd81f,
    16'hb80f, 16'hf807, 16'h51ff};
  always #10 core_clk_i = ~core_clk_i;
  ffoc_host u_host (.clk_i(core_clk_i), .go_i(go), .rd_i(rdsel), .n_i(n),
    .wr_en_o(wr_en), .rd_en_o(rd_en), .data_o(wdata));
  ffoc_top uut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .master_reset_n_i(mr_n), .load_method_select_i(lsel),
    .offset_select_hi_i(hi), .offset_select_lo_i(lo),
    .small_capacity_i(sm), .narrow_mode_i(nw), .wr_en_i(wr_en),
    .wr_data_i(wdata), .rd_en_i(rd_en), .prog_en_i(pen),
    .prog_sel_full_i(psel), .prog_value_i(pval), .offset_read_i(offrd),
    .parallel_output_bus_o(bus), .input_ready_flag_o(in_rdy),
    .output_ready_flag_o(orf), .almost_empty_flag_o(ae),
    .almost_full_flag_o(af), .serial_mode_o(ser));
  task check(input string what, input [17:0] seen, input [17:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task tick(input integer k);
    repeat (k) @(negedge core_clk_i);
  endtask
  task mreset(input [4:0] s);
    begin
      {lsel, hi, lo, sm, nw} <= s;
      mr_n <= 1'b0;
      tick(2);
      mr_n <= 1'b1;
      lsel <= 1'b1;
      tick(1);
    end
  endtask
  task offchk(input sel, input [10:0] exp);
    begin
      psel <= sel;
      offrd <= 1'b1;
      tick(2);
      check("offset", {7'h00, bus[10:0]}, {7'h00, exp});
      offrd <= 1'b0;
      tick(1);
    end
  endtask
  task prog(input sel, input [10:0] v);
    begin
      psel <= sel;
      pval <= v;
      pen <= 1'b1;
      tick(1);
      pen <= 1'b0;
      tick(1);
    end
  endtask
  task burst(input rd, input [3:0] k);
    begin
      rdsel <= rd;
      n <= k;
      go <= 1'b1;
      tick(1);
      go <= 1'b0;
      tick(k + 8);
    end
  endtask
  task close_out;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  always @(posedge core_clk_i) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      n_errors = n_errors + 1;
      close_out;
    end
  end
  initial begin
    tick(20);
    rst_n_i <= 1'b1;
    tick(1);
    check("reset flags", {in_rdy, orf, ae, af, ser}, 5'b01010);
    offchk(1'b0, 11'h07f);
    $display("reset test done");
    for (i = 0; i < 17; i = i + 1) begin
      r = rows[16*i +: 16];
      mreset(r[15:11]);
      check("mode", ser, r[15]);
      offchk(1'b0, r[10:0]);
      offchk(1'b1, r[10:0]);
    end
    $display("default table done");
    mreset(5'h1c);
    prog(1'b0, 11'h002);
    offchk(1'b0, 11'h007);
    mreset(5'h00);
    prog(1'b0, 11'h002);
    prog(1'b1, 11'h001);
    prog(1'b0, 11'h008);
    offchk(1'b0, 11'h002);
    offchk(1'b1, 11'h001);
    $display("programming test done");
    burst(1'b0, 4'h8);
    check("head", bus, 18'h2a508);
    check("full flags", {in_rdy, orf, ae}, 3'b101);
    burst(1'b0, 4'h1);
    burst(1'b1, 4'h1);
    check("head", bus, 18'h2a507);
    check("room", in_rdy, 1'b0);
    burst(1'b1, 4'h3);
    check("near empty", ae, 1'b1);
    burst(1'b1, 4'h1);
    check("near empty", ae, 1'b0);
    burst(1'b1, 4'h3);
    check("empty", orf, 1'b1);
    burst(1'b1, 4'h2);
    burst(1'b0, 4'h1);
    check("head", bus, 18'h2a501);
    check("empty", orf, 1'b0);
    $display("data path test done");
    rst_n_i <= 1'b0;
    tick(2);
    rst_n_i <= 1'b1;
    tick(1);
    check("reset flags", {in_rdy, orf, ae, af, ser}, 5'b01010);
    offchk(1'b1, 11'h07f);
    $display("mid run reset test done");
    close_out;
  end
endmodule // testbench
